// ### ovl_pkg.sv
// shared constants and types for the protection overlay link and both ends
package ovl_pkg;
	localparam int ADDR_W      = 24;
	localparam int DATA_W      = 16;
	localparam int BYTE_W      = 8;
	localparam int KEY_W       = 64;
	localparam int FRAME_BYTES = 6;
	localparam int RD_BIT      = 7;
	localparam int SECT_SHIFT  = 17;
	localparam int KEY_MODE_BIT = 2;
	localparam int ABORT_BIT   = 3;
	// timing
	localparam int SYS_PERIOD_NS  = 40;
	localparam int LINK_PERIOD_NS = 320;
	localparam int LINK_HALF_CYC  = LINK_PERIOD_NS / (2 * SYS_PERIOD_NS);
	localparam int GAP_CYC        = 2 * LINK_HALF_CYC;
	// command cycle addresses (low bits only, sector bits ignored)
	localparam int          CMD_ADDR_W = 12;
	localparam logic [11:0] ADDR_U1    = 12'h555;
	localparam logic [11:0] ADDR_U2    = 12'h2AA;
	// command cycle data codes
	localparam logic [15:0] CODE_AA        = 16'h00AA;
	localparam logic [15:0] CODE_55        = 16'h0055;
	localparam logic [15:0] CODE_CFG_ENT   = 16'h0040;
	localparam logic [15:0] CODE_KEY_ENT   = 16'h0060;
	localparam logic [15:0] CODE_LOCK_ENT  = 16'h00C0;
	localparam logic [15:0] CODE_ABORT_CLR = 16'h00F0;
	localparam logic [15:0] CODE_EXIT      = 16'h0090;
	localparam logic [15:0] CODE_PGM       = 16'h00A0;
	localparam logic [15:0] CODE_ERASE     = 16'h0080;
	localparam logic [15:0] CODE_ERASE_OK  = 16'h0030;
	localparam logic [15:0] CODE_UNL1      = 16'h0025;
	localparam logic [15:0] CODE_UNL2      = 16'h0003;
	localparam logic [15:0] CODE_UNL_END   = 16'h0029;
	// device word locations and reset values
	localparam logic [23:0] CFG_ADDR     = 24'h00_0000;
	localparam logic [23:0] KEY_WORDS    = 24'h00_0004;
	localparam logic [15:0] CFG_RST      = 16'hFFFF;
	localparam logic [15:0] ARRAY_ERASED = 16'hFFFF;
	// controller registers (byte offsets)
	localparam logic [11:0] REG_CTRL     = 12'h000;
	localparam logic [11:0] REG_ADDR     = 12'h004;
	localparam logic [11:0] REG_WDATA    = 12'h008;
	localparam logic [11:0] REG_RDATA    = 12'h00C;
	localparam logic [11:0] REG_STATUS   = 12'h010;
	localparam logic [11:0] REG_IRQ_STAT = 12'h014;
	localparam logic [11:0] REG_IRQ_CLR  = 12'h018;
	localparam logic [11:0] REG_IRQ_EN   = 12'h01C;
	localparam int CTRL_GO   = 0;
	localparam int CTRL_RD   = 1;
	localparam int IRQ_W     = 2;
	localparam int IRQ_WR    = 0;
	localparam int IRQ_RD    = 1;

	typedef enum logic [1:0] {OV_NONE, OV_CFG, OV_KEY, OV_LOCK} overlay_e;
endpackage : ovl_pkg

// ### ovl_link_if.sv
`timescale 1ns/1ns
// byte-wide flash link between the bus controller and the protection logic
interface ovl_link_if;
	logic       link_clk;
	logic       cs_n;
	logic [7:0] h_dq_out;
	logic       h_dq_oe_n;
	logic [7:0] d_dq_out;
	logic       d_dq_oe_n;
	logic [7:0] dq;

	// undriven bus floats high through the pull-ups
	assign dq = !h_dq_oe_n ? h_dq_out : (!d_dq_oe_n ? d_dq_out : 8'hFF);

	modport host (output link_clk, output cs_n, output h_dq_out, output h_dq_oe_n, input dq);
	modport dev (input link_clk, input cs_n, output d_dq_out, output d_dq_oe_n, input dq);
endinterface : ovl_link_if

// ### ovl_host.sv
`timescale 1ns/1ns
// bus controller end: apb registers drive single link cycles
module ovl_host
	import ovl_pkg::*;
#(
	parameter int LINK_HALF = LINK_HALF_CYC
) (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_n_i,
	ovl_link_if.host         link,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	output logic             irq_o
);
	typedef enum logic [1:0] {H_IDLE, H_RUN, H_GAP} host_st_e;

	typedef struct packed {
		host_st_e         st;
		logic [7:0]       div;
		logic             lclk;
		logic             cs_n;
		logic             oe_n;
		logic [7:0]       dout;
		logic [2:0]       bidx;
		logic             rd;
		logic [23:0]      addr;
		logic [15:0]      wdata;
		logic [15:0]      rdata;
		logic [7:0]       dq_s1;
		logic [7:0]       dq_s2;
		logic [IRQ_W-1:0] irq_stat;
		logic [IRQ_W-1:0] irq_en;
		logic [31:0]      prd;
	} host_s;

	localparam host_s HOST_RST = '{st: H_IDLE, cs_n: 1'b1, oe_n: 1'b1, default: '0};

	host_s       q, n;
	logic        acc;
	logic        mapped;
	logic [31:0] rd_mux;

	function automatic logic [7:0] byte_sel(input logic [2:0] idx, input host_s s);
		logic [7:0] b;
		b = '0;
		case (idx)
			3'd0: b = {s.rd, 7'h00};
			3'd1: b = s.addr[23:16];
			3'd2: b = s.addr[15:8];
			3'd3: b = s.addr[7:0];
			3'd4: b = s.wdata[15:8];
			default: b = s.wdata[7:0];
		endcase
		return b;
	endfunction : byte_sel

	always_comb begin
		n = q;
		n.dq_s1 = link.dq;
		n.dq_s2 = q.dq_s1;
		acc = psel_i & penable_i;
		mapped = (paddr_i == REG_CTRL) || (paddr_i == REG_ADDR) || (paddr_i == REG_WDATA) ||
			(paddr_i == REG_RDATA) || (paddr_i == REG_STATUS) || (paddr_i == REG_IRQ_STAT) ||
			(paddr_i == REG_IRQ_CLR) || (paddr_i == REG_IRQ_EN);
		// read data is captured in the setup cycle so the access phase shows a flop
		if (psel_i && !penable_i) begin
			n.prd = rd_mux;
		end
		if (acc && pwrite_i) begin
			if (paddr_i == REG_ADDR) begin
				n.addr = pwdata_i[23:0];
			end else if (paddr_i == REG_WDATA) begin
				n.wdata = pwdata_i[15:0];
			end else if (paddr_i == REG_IRQ_CLR) begin
				n.irq_stat = q.irq_stat & ~pwdata_i[IRQ_W-1:0];
			end else if (paddr_i == REG_IRQ_EN) begin
				n.irq_en = pwdata_i[IRQ_W-1:0];
			end else if (paddr_i == REG_CTRL && pwdata_i[CTRL_GO] && q.st == H_IDLE) begin
				// one link cycle per go; multi-cycle transactions are sequences of these
				n.st   = H_RUN;
				n.rd   = pwdata_i[CTRL_RD];
				n.cs_n = 1'b0;
				n.oe_n = 1'b0;
				n.bidx = '0;
				n.div  = '0;
				n.lclk = 1'b0;
				n.dout = {pwdata_i[CTRL_RD], 7'h00};
			end
		end
		case (q.st)
			H_RUN: begin
				if (q.div == 8'(LINK_HALF - 1)) begin
					n.div  = '0;
					n.lclk = ~q.lclk;
					if (q.lclk) begin
						// falling edge: take read byte, then launch the next one
						if (q.rd && q.bidx >= 3'd4) begin
							n.rdata = {q.rdata[7:0], q.dq_s2};
						end
						n.bidx = q.bidx + 3'd1;
						if (q.bidx == 3'(FRAME_BYTES - 1)) begin
							n.st   = H_GAP;
							n.cs_n = 1'b1;
							n.oe_n = 1'b1;
							n.irq_stat[q.rd ? IRQ_RD : IRQ_WR] = 1'b1;
						end else begin
							n.dout = byte_sel(q.bidx + 3'd1, q);
							n.oe_n = q.rd && (q.bidx + 3'd1 >= 3'd4);
						end
					end
				end else begin
					n.div = q.div + 8'd1;
				end
			end
			H_GAP: begin
				n.div = q.div + 8'd1;
				if (q.div == 8'(GAP_CYC - 1)) begin
					n.st  = H_IDLE;
					n.div = '0;
				end
			end
			default: ;
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= HOST_RST;
		end else begin
			q <= n;
		end
	end

	always_comb begin
		rd_mux = '0;
		if (paddr_i == REG_ADDR) begin
			rd_mux = {8'h00, q.addr};
		end else if (paddr_i == REG_WDATA) begin
			rd_mux = {16'h0000, q.wdata};
		end else if (paddr_i == REG_RDATA) begin
			rd_mux = {16'h0000, q.rdata};
		end else if (paddr_i == REG_STATUS) begin
			rd_mux = {31'h0000_0000, q.st != H_IDLE};
		end else if (paddr_i == REG_IRQ_STAT) begin
			rd_mux = {30'h0000_0000, q.irq_stat};
		end else if (paddr_i == REG_IRQ_EN) begin
			rd_mux = {30'h0000_0000, q.irq_en};
		end
	end

	assign prdata_o       = q.prd;
	assign pready_o       = 1'b1;
	assign pslverr_o      = acc & ~mapped;
	assign irq_o          = |(q.irq_stat & q.irq_en);
	assign link.link_clk  = q.lclk;
	assign link.cs_n      = q.cs_n;
	assign link.h_dq_out  = q.dout;
	assign link.h_dq_oe_n = q.oe_n;
endmodule : ovl_host

// ### ovl_dev.sv
`timescale 1ns/1ns
// flash end: protection overlays for config word, secret key and sector locks
// Summary of operation
// - config overlay entry: three cycles, sector ignored
// - config word sits at word zero
// - two-cycle program writes the config word
// - one-cycle read at zero returns config
// - one-cycle exit returns to array reads
// - key overlay entry maps key words 0-3
// - program stores the 64-bit key
// - one-cycle read returns key words 0-3
// - seven-cycle unlock compares presented key
// - sector lock bit in bit 0
// - two-cycle program sets addressed sector lock, or the abort flag while key mode is active and the key still locked
// - two-cycle erase clears all sector locks unless key mode is active and the key still locked
// - three-cycle reset clears abort flag bit 3
// - one-cycle read returns addressed sector lock
module ovl_dev
	import ovl_pkg::*;
#(
	parameter int SECT_LSB = SECT_SHIFT
) (
	input  wire logic                             clk_sys_i,
	input  wire logic                             rst_n_i,
	ovl_link_if.dev                               link,
	output logic     [1:0]                        overlay_o,
	output logic                                  key_locked_o,
	output logic     [7:0]                        volatile_status_o,
	output logic     [DATA_W-1:0]                 cfg_word_o,
	output logic     [(1 << (ADDR_W - SECT_LSB))-1:0] sector_lock_o
);
	localparam int SECT_W = ADDR_W - SECT_LSB;
	localparam int NSECT  = 1 << SECT_W;

	typedef enum logic [3:0] {
		STEP_IDLE, STEP_P1, STEP_P2, STEP_PGM, STEP_ERS, STEP_U1,
		STEP_W0, STEP_W1, STEP_W2, STEP_W3, STEP_UE
	} step_e;

	typedef struct packed {
		logic             clk_s1;
		logic             clk_s2;
		logic             clk_s3;
		logic             cs_s1;
		logic             cs_s2;
		logic [7:0]       dq_s1;
		logic [7:0]       dq_s2;
		logic [2:0]       bcnt;
		logic [7:0]       ctrl;
		logic [23:0]      addr;
		logic [7:0]       wd_hi;
		logic [7:0]       dout;
		logic             oe_n;
		overlay_e         ov;
		step_e            step;
		logic [KEY_W-1:0] cand;
		logic [15:0]      cfg;
		logic [KEY_W-1:0] key;
		logic             locked;
		logic             abort;
		logic [NSECT-1:0] lock;
	} dev_s;

	localparam dev_s DEV_RST = '{
		clk_s1: 1'b0, clk_s2: 1'b0, clk_s3: 1'b0,
		cs_s1: 1'b1, cs_s2: 1'b1,
		oe_n: 1'b1, ov: OV_NONE, step: STEP_IDLE,
		cfg: CFG_RST, key: '1, locked: 1'b1,
		default: '0
	};

	dev_s              q, n;
	logic              rise;
	logic              fall;
	logic [15:0]       wd;
	logic [15:0]       rd_word;
	logic [SECT_W-1:0] sect;
	logic              u1_hit;
	logic              guarded;

	always_comb begin
		n = q;
		// link pins pass two flops before any logic looks at them
		n.clk_s1 = link.link_clk;
		n.clk_s2 = q.clk_s1;
		n.clk_s3 = q.clk_s2;
		n.cs_s1  = link.cs_n;
		n.cs_s2  = q.cs_s1;
		n.dq_s1  = link.dq;
		n.dq_s2  = q.dq_s1;
		rise     = q.clk_s2 & ~q.clk_s3 & ~q.cs_s2;
		fall     = ~q.clk_s2 & q.clk_s3 & ~q.cs_s2;
		wd       = {q.wd_hi, q.dq_s2};
		sect     = q.addr[ADDR_W-1:SECT_LSB];
		u1_hit   = q.addr[CMD_ADDR_W-1:0] == ADDR_U1;
		// key mode active and not yet unlocked
		guarded  = ~q.cfg[KEY_MODE_BIT] & q.locked;

		rd_word = ARRAY_ERASED;
		case (q.ov)
			OV_CFG: begin
				if (q.addr == CFG_ADDR) begin
					rd_word = q.cfg;
				end
			end
			OV_KEY: begin
				if (q.addr < KEY_WORDS) begin
					rd_word = q.key[q.addr[1:0]*DATA_W +: DATA_W];
				end
			end
			OV_LOCK: begin
				rd_word = {{(DATA_W-1){1'b0}}, q.lock[sect]};
			end
			default: ;
		endcase

		if (q.cs_s2) begin
			n.bcnt = '0;
			n.oe_n = 1'b1;
		end else if (rise && q.bcnt < 3'(FRAME_BYTES)) begin
			n.bcnt = q.bcnt + 3'd1;
			case (q.bcnt)
				3'd0: n.ctrl = q.dq_s2;
				3'd1: n.addr[23:16] = q.dq_s2;
				3'd2: n.addr[15:8] = q.dq_s2;
				3'd3: n.addr[7:0] = q.dq_s2;
				3'd4: n.wd_hi = q.dq_s2;
				default: begin
					if (!q.ctrl[RD_BIT]) begin
						n.step = STEP_IDLE;
						if (q.step == STEP_IDLE && q.ov != OV_NONE && wd == CODE_EXIT) begin
							n.ov = OV_NONE;
						end else begin
							case (q.step)
								STEP_IDLE: begin
									if (u1_hit && wd == CODE_AA) begin
										n.step = STEP_P1;
									end else if (q.ov != OV_NONE && wd == CODE_PGM) begin
										n.step = STEP_PGM;
									end else if (q.ov == OV_LOCK && wd == CODE_ERASE) begin
										n.step = STEP_ERS;
									end else if (q.ov == OV_KEY && wd == CODE_UNL1) begin
										n.step = STEP_U1;
									end
								end
								STEP_P1: begin
									if (q.addr[CMD_ADDR_W-1:0] == ADDR_U2 && wd == CODE_55) begin
										n.step = STEP_P2;
									end
								end
								STEP_P2: begin
									// entries compare only the low address bits
									if (u1_hit && q.ov == OV_NONE && wd == CODE_CFG_ENT) begin
										n.ov = OV_CFG;
									end else if (u1_hit && q.ov == OV_NONE && wd == CODE_KEY_ENT) begin
										n.ov = OV_KEY;
									end else if (u1_hit && q.ov == OV_NONE && wd == CODE_LOCK_ENT) begin
										n.ov = OV_LOCK;
									end else if (u1_hit && q.ov == OV_LOCK && wd == CODE_ABORT_CLR) begin
										n.abort = 1'b0;
									end
								end
								STEP_PGM: begin
									// programming only clears bits of the otp words
									case (q.ov)
										OV_CFG: begin
											if (q.addr == CFG_ADDR) begin
												n.cfg = q.cfg & wd;
											end
										end
										OV_KEY: begin
											if (q.addr < KEY_WORDS) begin
												n.key[q.addr[1:0]*DATA_W +: DATA_W] =
													q.key[q.addr[1:0]*DATA_W +: DATA_W] & wd;
											end
										end
										OV_LOCK: begin
											if (guarded) begin
												n.abort = 1'b1;
											end else begin
												n.lock[sect] = 1'b1;
											end
										end
										default: ;
									endcase
								end
								STEP_ERS: begin
									if (wd == CODE_ERASE_OK && !guarded) begin
										n.lock = '0;
									end
								end
								STEP_U1: begin
									if (wd == CODE_UNL2) begin
										n.step = STEP_W0;
									end
								end
								STEP_UE: begin
									if (wd == CODE_UNL_END && q.cand == q.key) begin
										n.locked = 1'b0;
									end
								end
								default: begin
									if (q.step >= STEP_W0 && q.step <= STEP_W3) begin
										n.cand[(q.step - STEP_W0)*DATA_W +: DATA_W] = wd;
										n.step = step_e'(q.step + 4'h1);
									end
								end
							endcase
						end
					end
				end
			endcase
		end else if (fall && q.ctrl[RD_BIT]) begin
			if (q.bcnt == 3'd4) begin
				n.oe_n = 1'b0;
				n.dout = rd_word[15:8];
			end else if (q.bcnt == 3'd5) begin
				n.dout = rd_word[7:0];
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= DEV_RST;
		end else begin
			q <= n;
		end
	end

	assign link.d_dq_out  = q.dout;
	assign link.d_dq_oe_n = q.oe_n;
	assign overlay_o      = q.ov;
	assign key_locked_o   = q.locked;
	assign cfg_word_o     = q.cfg;
	assign sector_lock_o  = q.lock;

	always_comb begin
		volatile_status_o            = 8'h00;
		volatile_status_o[ABORT_BIT] = q.abort;
	end
endmodule : ovl_dev

// ### ovl_sva.sv
`timescale 1ns/1ns
// link protocol checker between the bus controller end and the protection logic
module ovl_sva (
	input wire logic       clk_sys_i,
	input wire logic       rst_n_i,
	input wire logic       link_clk_i,
	input wire logic       cs_n_i,
	input wire logic       h_dq_oe_n_i,
	input wire logic       d_dq_oe_n_i,
	input wire logic [7:0] dq_i
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	logic [3:0] rises_q;
	logic       rd_q;
	// count link rises per frame and note the frame direction
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rises_q <= 4'h0;
			rd_q    <= 1'b0;
		end else if ($fell(cs_n_i)) begin
			rises_q <= 4'h0;
			rd_q    <= dq_i[7];
		end else if ($rose(link_clk_i) && !cs_n_i) begin
			rises_q <= rises_q + 4'h1;
		end
	end
	property p_frame_len; $rose(cs_n_i) |-> rises_q == 4'h6; endproperty
	a_frame_len: assert property (p_frame_len) else $error("frame not six bytes");
	property p_gap; $rose(cs_n_i) |-> cs_n_i [*8]; endproperty
	a_gap: assert property (p_gap) else $error("frame gap too short");
	property p_half; $rose(link_clk_i) |-> link_clk_i [*4] ##1 !link_clk_i; endproperty
	a_half: assert property (p_half) else $error("link clock high phase wrong");
	property p_idle; cs_n_i |-> !link_clk_i && h_dq_oe_n_i; endproperty
	a_idle: assert property (p_idle) else $error("link not idle outside frame");
	property p_first; $fell(cs_n_i) |-> !h_dq_oe_n_i && dq_i[6:0] == 7'h00; endproperty
	a_first: assert property (p_first) else $error("bad control byte");
	property p_hold; $rose(link_clk_i) && !h_dq_oe_n_i |-> ##1 $stable(dq_i) [*3]; endproperty
	a_hold: assert property (p_hold) else $error("host byte moved");
	property p_nocont; !h_dq_oe_n_i |-> d_dq_oe_n_i; endproperty
	a_nocont: assert property (p_nocont) else $error("bus contention");
	property p_dev_rd; !d_dq_oe_n_i |-> rd_q && h_dq_oe_n_i; endproperty
	a_dev_rd: assert property (p_dev_rd) else $error("device drives in write frame");
	property p_dev_rel; cs_n_i [*6] |-> d_dq_oe_n_i; endproperty
	a_dev_rel: assert property (p_dev_rel) else $error("device holds bus after frame");
	c_rd: cover property ($fell(cs_n_i) ##1 rd_q);
	c_wr: cover property ($rose(cs_n_i) && !rd_q);
	c_dev: cover property ($fell(d_dq_oe_n_i));
endmodule : ovl_sva

// ### tb_top.sv
`timescale 1ns/1ns
// self-checking bench: bus controller and protection logic joined over the link
module tb_top;
	import ovl_pkg::*;
	logic         clk_sys_i = 1'b0;
	logic         rst_n_i = 1'b0;
	logic         psel = 1'b0;
	logic         penable = 1'b0;
	logic         pwrite = 1'b0;
	logic [11:0]  paddr = 12'h000;
	logic [31:0]  pwdata = 32'h0000_0000;
	logic [31:0]  prdata;
	logic         pready;
	logic         pslverr;
	logic         irq;
	logic [1:0]   ovl;
	logic         locked;
	logic [7:0]   vstat;
	logic [15:0]  cfg;
	logic [127:0] locks;
	logic [31:0]  rd;
	logic         er;
	int           err_count = 0;
	int           total_checks = 0;
	int           cyc = 0;
	ovl_link_if link ();
	ovl_host ovl_host_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .link(link), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq));
	ovl_dev ovl_dev_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .link(link), .overlay_o(ovl),
		.key_locked_o(locked), .volatile_status_o(vstat), .cfg_word_o(cfg),
		.sector_lock_o(locks));
	ovl_sva ovl_sva_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .link_clk_i(link.link_clk),
		.cs_n_i(link.cs_n), .h_dq_oe_n_i(link.h_dq_oe_n), .d_dq_oe_n_i(link.d_dq_oe_n),
		.dq_i(link.dq));
	initial begin
		forever #20 clk_sys_i = ~clk_sys_i;
	end
	task print_verdict();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			$display("BAD %0t run timed out", $time);
			print_verdict();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t %s got %h want %h", $time, m, got, exp);
		end
	endtask : chk
	// one apb transfer, entered just after a rising edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys_i) penable <= 1'b1;
		do @(posedge clk_sys_i); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys_i);
	endtask : apb
	task link_op(input logic [23:0] a, input logic [15:0] d, input logic r);
		apb(1'b1, REG_ADDR, {8'h00, a});
		apb(1'b1, REG_WDATA, {16'h0000, d});
		apb(1'b1, REG_CTRL, {30'h0, r, 1'b1});
		apb(1'b0, REG_STATUS, 32'h0);
		while (rd[0] !== 1'b0) apb(1'b0, REG_STATUS, 32'h0);
		if (r) apb(1'b0, REG_RDATA, 32'h0);
	endtask : link_op
	task lw(input logic [23:0] a, input logic [15:0] d);
		link_op(a, d, 1'b0);
	endtask : lw
	task lr(input logic [23:0] a, input logic [15:0] exp);
		link_op(a, 16'h0000, 1'b1);
		chk(rd, {16'h0000, exp}, "link read");
	endtask : lr
	task entry(input logic [15:0] code, input logic [23:0] s);
		lw({s[23:12], ADDR_U1}, CODE_AA);
		lw({s[23:12], ADDR_U2}, CODE_55);
		lw({s[23:12], ADDR_U1}, code);
	endtask : entry
	task t_reset();
		chk({30'h0, ovl}, 0, "overlay");
		chk({16'h0, cfg}, CFG_RST, "cfg reset");
		chk({31'h0, locked}, 1, "key lock reset");
		chk({31'h0, |locks}, 0, "sector lock reset");
		apb(1'b0, 12'h020, 32'h0);
		chk({31'h0, er}, 1, "unmapped");
		apb(1'b0, REG_IRQ_EN, 32'h0);
		chk(rd, 0, "irq en reset");
		lr(CFG_ADDR, ARRAY_ERASED);
		$display("test reset done");
	endtask : t_reset
	task t_cfg();
		apb(1'b1, REG_IRQ_CLR, 32'h3);
		apb(1'b1, REG_IRQ_EN, 32'h1);
		entry(CODE_CFG_ENT, 24'h3A_0000);
		chk({30'h0, ovl}, 1, "cfg entry");
		chk({31'h0, irq}, 1, "irq raised");
		apb(1'b1, REG_IRQ_CLR, 32'h1);
		chk({31'h0, irq}, 0, "irq cleared");
		lr(CFG_ADDR, CFG_RST);
		chk({31'h0, irq}, 0, "irq masked");
		apb(1'b0, REG_IRQ_STAT, 32'h0);
		chk(rd, 2, "irq status");
		lw(24'h12_0000, CODE_PGM);
		lw(CFG_ADDR, 16'hFFFB);
		chk({16'h0, cfg}, 16'hFFFB, "cfg program");
		lr(CFG_ADDR, 16'hFFFB);
		lr(24'h00_0001, 16'hFFFF);
		lw(24'h00_0000, CODE_EXIT);
		chk({30'h0, ovl}, 0, "cfg exit");
		lr(CFG_ADDR, ARRAY_ERASED);
		$display("test cfg done");
	endtask : t_cfg
	task t_abort();
		entry(CODE_LOCK_ENT, 24'h7F_0000);
		chk({30'h0, ovl}, 3, "lock entry");
		lw(24'h00_0000, CODE_PGM);
		lw(24'h0A_0000, 16'h0000);
		chk({24'h0, vstat}, 32'h8, "abort set");
		chk({31'h0, locks[5]}, 0, "locked program");
		entry(CODE_ABORT_CLR, 24'h00_0000);
		chk({24'h0, vstat}, 0, "abort clear");
		lw(24'h00_0000, CODE_EXIT);
		$display("test abort done");
	endtask : t_abort
	task unlock(input logic [15:0] w1);
		lw(24'h00_0000, CODE_UNL1);
		lw(24'h00_0000, CODE_UNL2);
		for (int i = 0; i < 4; i++) lw(24'(i), (i == 1) ? w1 : 16'hFFFF);
		lw(24'h00_0000, CODE_UNL_END);
	endtask : unlock
	task t_key();
		entry(CODE_KEY_ENT, 24'h55_0000);
		chk({30'h0, ovl}, 2, "key entry");
		lw(24'h00_0000, CODE_PGM);
		lw(24'h00_0001, 16'h1234);
		for (int i = 0; i < 4; i++) lr(24'(i), (i == 1) ? 16'h1234 : 16'hFFFF);
		unlock(16'h1235);
		chk({31'h0, locked}, 1, "wrong key");
		unlock(16'h1234);
		chk({31'h0, locked}, 0, "right key");
		lw(24'h00_0000, CODE_EXIT);
		$display("test key done");
	endtask : t_key
	task t_lock();
		entry(CODE_LOCK_ENT, 24'h00_0000);
		lw(24'h00_0000, CODE_PGM);
		lw(24'h0A_0000, 16'h0000);
		chk({29'h0, locks[6:4]}, 32'h2, "sector program");
		link_op(24'h0B_FFFE, 16'h0000, 1'b1);
		chk({31'h0, rd[0]}, 1, "lock read top");
		link_op(24'h0A_0003, 16'h0000, 1'b1);
		chk({31'h0, rd[0]}, 1, "lock read low");
		link_op(24'h09_0000, 16'h0000, 1'b1);
		chk({31'h0, rd[0]}, 0, "other sector");
		lw(24'h00_0000, CODE_ERASE);
		lw(24'h00_0000, CODE_ERASE_OK);
		chk({31'h0, |locks}, 0, "erase all");
		lw(24'h00_0000, CODE_EXIT);
		chk({30'h0, ovl}, 0, "lock exit");
		$display("test lock done");
	endtask : t_lock
	initial begin
		repeat (8) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		@(posedge clk_sys_i);
		t_reset();
		t_cfg();
		t_abort();
		t_key();
		t_lock();
		print_verdict();
	end
endmodule : tb_top
